// [pdm_pkg.sv]
`default_nettype none

package pdm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MASTER_CLOCK_SELECT = 8'h14;
    localparam logic [7:0] ADDR_PORT2_DIRECTION     = 8'h25;
    localparam logic [7:0] ADDR_PORT2_OUTPUT_MUX    = 8'h27;
    localparam logic [7:0] ADDR_DENSITY_WORD_HIGH   = 8'h30;
    localparam logic [7:0] ADDR_DENSITY_WORD_LOW    = 8'h31;
    localparam logic [7:0] ADDR_MODULATOR_CONTROL   = 8'h36;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN_BIT          = 2;
    localparam int MUX_SELECT_BIT   = 4;
    localparam int ENABLE_BIT       = 5;
    localparam int OUT_LEVEL_BIT    = 7;
    localparam int CLK_SEL_LSB      = 0;
    localparam int CLK_SEL_WIDTH    = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MASTER_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] RST_PORT2_DIRECTION     = 8'h00;
    localparam logic [7:0] RST_PORT2_OUTPUT_MUX    = 8'h00;
    localparam logic [7:0] RST_DENSITY_WORD_HIGH   = 8'h00;
    localparam logic [7:0] RST_DENSITY_WORD_LOW    = 8'h00;
    localparam logic [7:0] RST_MODULATOR_CONTROL   = 8'h00;

    // Answer to an unmapped read
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int DENSITY_WIDTH  = 16;
    localparam int PRESCALE_WIDTH = 7;

endpackage : pdm_pkg

`default_nettype wire

// [pdm_sub_rate.sv]
`default_nettype none

// Sixteen binary-weighted pulse trains from one free-running counter.
module pdm_sub_rate #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Control
    input  wire logic             run,
    input  wire logic             tick,
    // Pulse trains, bit k at tick rate over 2**(WIDTH-k)
    output logic [WIDTH-1:0]      subRate
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 2 || WIDTH > 16) begin : gWidthCheck
        $error("pdm_sub_rate: WIDTH must lie in 2..16");
    end

    logic [WIDTH-1:0] count;

    // Free-running count; cleared while stopped so each start is alike
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // Train k fires when the lowest set count bit is WIDTH-1-k.
    // Lowest-set-bit decode keeps trains disjoint, so they may be ORed.
    for (genvar k = 0; k < WIDTH; k++) begin : gTrain
        localparam int P = WIDTH - 1 - k;
        if (P == 0) begin : gLsb
            assign subRate[k] = count[0];
        end else begin : gUpper
            assign subRate[k] = count[P] && (count[P-1:0] == '0);
        end
    end

endmodule : pdm_sub_rate

`default_nettype wire

// [pdm_modulator.sv]
`default_nettype none

// Function
// - 16-bit density word from two byte registers
// - Bit k runs at modulator rate over 2**(16-k)
// - Cleared bit includes its train, set excludes
// - Enable runs modulator; disabled leaves pin GPIO
// - Selector divides master clock by 2**value
// - Mux bit routes modulator output to pin
// - Direction bit 2 must be output to drive
// - Output is OR of all selected trains
// - Mux select sits at bit 4, 1 selects modulator
module pdm_modulator #(
    parameter int DENSITY_WIDTH  = pdm_pkg::DENSITY_WIDTH,
    parameter int PRESCALE_WIDTH = pdm_pkg::PRESCALE_WIDTH
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,

    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,

    // GPIO side of port 2 bit 2
    input  wire logic        gpioLatch,

    // Port 2 bit 2 pin drive
    output logic             pinOut,
    output logic             pinOe,

    // Master clock source selection, handed to the clock generator
    output logic      [7:0]  masterClockSelect
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DENSITY_WIDTH != 16) begin : gDensityCheck
        $error("pdm_modulator: density word is two bytes wide");
    end

    if (PRESCALE_WIDTH != 7) begin : gPrescaleCheck
        $error("pdm_modulator: 3-bit selector needs a 7-bit prescaler");
    end

    // ------------------------------------------------------------
    // Operating notes
    // ------------------------------------------------------------
    // Everything runs on clk_sys. The modulator clock is never a real
    // clock: it is the one-cycle enable modTick, raised once every
    // 2**select cycles by the free-running prescaler.
    //
    // Each tick steps a 16-bit counter. Train k pulses on the ticks at
    // which the lowest set counter bit is 15-k, so train 15 takes every
    // second tick and train 0 one tick in 65536. No two trains pulse on
    // the same tick, which is what lets the level be a plain OR.
    //
    // Polarity: a density bit at zero includes its train and a bit at
    // one leaves it out. The high time per 65536 ticks is therefore the
    // inverse of the word, and a word of all ones keeps the level low.
    // Full duty cannot be reached; software parks the pin on the GPIO
    // latch and sets the latch instead.
    //
    // The level is registered on each tick and the pin drive once more
    // on every cycle, so the pin shows a tick's result two edges later.
    //
    // Setup is expected in this order: master clock, enable, selector,
    // density word, direction, then the mux. Nothing here enforces it;
    // a mux set before the enable leaves the pin on the GPIO latch.
    //
    // Clearing the enable parks prescaler, counter and level at zero,
    // so every restart begins at the same phase.
    //
    // Reads have no side effects, so software may poll the control
    // register for the live level bit at any rate.

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]               port2Direction;
    logic                     muxSelect;
    logic [7:0]               densityHigh;
    logic [7:0]               densityLow;
    logic                     modulatorEnable;
    logic [2:0]               clockDivSelect;

    // ------------------------------------------------------------
    // Datapath signals
    // ------------------------------------------------------------
    logic [DENSITY_WIDTH-1:0]  densityWord;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [PRESCALE_WIDTH-1:0] divMask;
    logic                      modTick;
    logic [DENSITY_WIDTH-1:0]  subRate;
    logic [DENSITY_WIDTH-1:0]  trainSelect;
    logic [DENSITY_WIDTH-1:0]  includedTrains;
    logic                      next_pdmLevel;
    logic                      pdmLevel;
    logic                      routeModulator;
    logic                      next_pinOut;
    logic [7:0]                next_regRdData;

    // Decoded write strobes
    logic wrMasterClock;
    logic wrDirection;
    logic wrOutputMux;
    logic wrDensityHigh;
    logic wrDensityLow;
    logic wrControl;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // One strobe per register; unmapped writes fall through unused.
    // Addresses are compared in full, so no register has an alias.
    assign wrMasterClock = regWrite && (regAddr == pdm_pkg::ADDR_MASTER_CLOCK_SELECT);
    assign wrDirection   = regWrite && (regAddr == pdm_pkg::ADDR_PORT2_DIRECTION);
    assign wrOutputMux   = regWrite && (regAddr == pdm_pkg::ADDR_PORT2_OUTPUT_MUX);
    assign wrDensityHigh = regWrite && (regAddr == pdm_pkg::ADDR_DENSITY_WORD_HIGH);
    assign wrDensityLow  = regWrite && (regAddr == pdm_pkg::ADDR_DENSITY_WORD_LOW);
    assign wrControl     = regWrite && (regAddr == pdm_pkg::ADDR_MODULATOR_CONTROL);

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------

    // Master clock source byte; only stored and passed on
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            masterClockSelect <= pdm_pkg::RST_MASTER_CLOCK_SELECT;
        end else if (wrMasterClock) begin
            masterClockSelect <= regWrData;
        end
    end

    // Port 2 direction; only bit 2 matters to this block
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port2Direction <= pdm_pkg::RST_PORT2_DIRECTION;
        end else if (wrDirection) begin
            port2Direction <= regWrData;
        end
    end

    // Output mux select; the other bits are unimplemented
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            muxSelect <= pdm_pkg::RST_PORT2_OUTPUT_MUX[pdm_pkg::MUX_SELECT_BIT];
        end else if (wrOutputMux) begin
            muxSelect <= regWrData[pdm_pkg::MUX_SELECT_BIT];
        end
    end

    // Density word high byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            densityHigh <= pdm_pkg::RST_DENSITY_WORD_HIGH;
        end else if (wrDensityHigh) begin
            densityHigh <= regWrData;
        end
    end

    // Density word low byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            densityLow <= pdm_pkg::RST_DENSITY_WORD_LOW;
        end else if (wrDensityLow) begin
            densityLow <= regWrData;
        end
    end

    // Bytes take effect one at a time; a half-written word can show
    // for a few ticks, which software avoids by writing while stopped.
    assign densityWord = {densityHigh, densityLow};

    // Modulator enable; clearing it also parks divider and trains
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            modulatorEnable <= pdm_pkg::RST_MODULATOR_CONTROL[pdm_pkg::ENABLE_BIT];
        end else if (wrControl) begin
            modulatorEnable <= regWrData[pdm_pkg::ENABLE_BIT];
        end
    end

    // Clock selector; a change while running takes effect at once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clockDivSelect <= pdm_pkg::RST_MODULATOR_CONTROL[pdm_pkg::CLK_SEL_LSB +:
                                                             pdm_pkg::CLK_SEL_WIDTH];
        end else if (wrControl) begin
            clockDivSelect <= regWrData[pdm_pkg::CLK_SEL_LSB +: pdm_pkg::CLK_SEL_WIDTH];
        end
    end

    // ------------------------------------------------------------
    // Modulator clock divider
    // ------------------------------------------------------------

    // Low selector bits of the prescaler that must all be ones.
    // The widest setting needs all seven bits, hence the width check.
    always_comb begin
        divMask = '0;
        for (int i = 0; i < PRESCALE_WIDTH; i++) begin
            if (i < int'(clockDivSelect)) begin
                divMask[i] = 1'b1;
            end
        end
    end

    // Free-running prescaler, held clear while stopped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prescale <= '0;
        end else if (!modulatorEnable) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // One tick every 2**select cycles; select 0 ticks every cycle.
    // A selector change mid-run only shifts phase, never stalls.
    assign modTick = modulatorEnable && ((prescale & divMask) == divMask);

    // ------------------------------------------------------------
    // Pulse trains
    // ------------------------------------------------------------
    pdm_sub_rate #(
        .WIDTH   (DENSITY_WIDTH)
    ) uSubRate (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .run     (modulatorEnable),
        .tick    (modTick),
        .subRate (subRate)
    );

    // ------------------------------------------------------------
    // Output combination
    // ------------------------------------------------------------

    // A cleared word bit lets its train through, so all ones is silence
    // and no setting reaches full duty: software keeps that for GPIO.
    assign trainSelect = ~densityWord;

    // Trains never overlap, so a plain OR adds their densities
    assign includedTrains = subRate & trainSelect;
    assign next_pdmLevel  = |includedTrains;

    // Level updates only on modulator ticks so each pulse spans a tick
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pdmLevel <= 1'b0;
        end else if (!modulatorEnable) begin
            pdmLevel <= 1'b0;
        end else if (modTick) begin
            pdmLevel <= next_pdmLevel;
        end
    end

    // ------------------------------------------------------------
    // Pin multiplexer
    // ------------------------------------------------------------

    // Modulator reaches the pin only while both enable and mux are set
    assign routeModulator = modulatorEnable && muxSelect;

    // Full duty is left to software through the GPIO path
    assign next_pinOut = routeModulator ? pdmLevel : gpioLatch;

    // Registered pin level; costs one cycle but keeps glitches off pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinOut <= 1'b0;
        end else begin
            pinOut <= next_pinOut;
        end
    end

    // Output enable follows direction bit 2 whatever the mux says, so
    // the modulator never drives a pin that software left as input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinOe <= 1'b0;
        end else begin
            pinOe <= port2Direction[pdm_pkg::PIN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Unimplemented bits read as zero; bit 7 of control shows the level.
    // That bit is a live view only; writes to it are dropped.
    always_comb begin
        next_regRdData = pdm_pkg::READ_UNMAPPED;
        unique case (regAddr)
            pdm_pkg::ADDR_MASTER_CLOCK_SELECT: begin
                next_regRdData = masterClockSelect;
            end
            pdm_pkg::ADDR_PORT2_DIRECTION: begin
                next_regRdData = port2Direction;
            end
            pdm_pkg::ADDR_PORT2_OUTPUT_MUX: begin
                next_regRdData[pdm_pkg::MUX_SELECT_BIT] = muxSelect;
            end
            pdm_pkg::ADDR_DENSITY_WORD_HIGH: begin
                next_regRdData = densityHigh;
            end
            pdm_pkg::ADDR_DENSITY_WORD_LOW: begin
                next_regRdData = densityLow;
            end
            pdm_pkg::ADDR_MODULATOR_CONTROL: begin
                next_regRdData[pdm_pkg::OUT_LEVEL_BIT] = pdmLevel;
                next_regRdData[pdm_pkg::ENABLE_BIT]    = modulatorEnable;
                next_regRdData[2:0]                    = clockDivSelect;
            end
            default: begin
                next_regRdData = pdm_pkg::READ_UNMAPPED;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe, else zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule : pdm_modulator

`default_nettype wire

// [pdm_modulator_monitor.sv]
`default_nettype none

module pdm_modulator_monitor #(
    parameter int DENSITY_WIDTH  = 16,
    parameter int PRESCALE_WIDTH = 7
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // Pin side
    input wire logic       gpioLatch,
    input wire logic       pinOut,
    input wire logic       pinOe,
    input wire logic [7:0] masterClockSelect
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Shadow state, rebuilt from bus writes
    // ----------------------------------------
    logic [15:0] word;
    logic [7:0]  ctl;
    logic        mux;
    logic [1:0]  upCnt;
    logic        run;

    // Shadows move on the same edges as the registers they copy
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            word <= 16'h0000;
            ctl  <= 8'h00;
            mux  <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == 8'h30) word[15:8] <= regWrData;
            if (regAddr == 8'h31) word[7:0] <= regWrData;
            if (regAddr == 8'h36) ctl <= regWrData;
            if (regAddr == 8'h27) mux <= regWrData[4];
        end
    end

    // Pin outputs lag reset release by two edges, so wait before judging
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) upCnt <= 2'h0;
        else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
    end

    assign run = ctl[5] && mux;

    chk_unmapped_zero: assert property (regRead && !(regAddr inside
        {8'h14, 8'h25, 8'h27, 8'h30, 8'h31, 8'h36}) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_clock_select: assert property (regWrite && regAddr == 8'h14 |=>
        masterClockSelect == $past(regWrData)) else $error("clock select not stored");
    chk_word_readback: assert property (regRead && regAddr == 8'h30 |=>
        regRdData == $past(word[15:8])) else $error("density high readback wrong");
    chk_mux_bit: assert property (regRead && regAddr == 8'h27 |=>
        regRdData == {3'h0, $past(mux), 4'h0}) else $error("mux readback wrong");
    chk_ctl_bits: assert property (regRead && regAddr == 8'h36 |=>
        regRdData[6:0] == ($past(ctl[6:0]) & 7'h27)) else $error("control readback wrong");
    chk_dir_to_oe: assert property (regWrite && regAddr == 8'h25 |=> ##1
        pinOe == $past(regWrData[2], 2)) else $error("enable does not follow direction");
    chk_gpio_path: assert property (upCnt == 2'h3 && !run |=>
        pinOut == $past(gpioLatch)) else $error("pin not on gpio latch");
    chk_half_rate: assert property (
        (run && ctl[2:0] == 3'h0 && word == 16'h7FFF) [*8] |-> pinOut != $past(pinOut))
        else $error("half rate train not toggling");
    chk_level_readback: assert property (regRead && regAddr == 8'h36 && run |=>
        regRdData[7] == pinOut) else $error("level readback not on pin");

    cover property (run && word == 16'hFFFF);
    cover property (run && ctl[2:0] == 3'h7);
    cover property (regRead && regAddr == 8'h24);

endmodule : pdm_modulator_monitor

bind pdm_modulator pdm_modulator_monitor #(
    .DENSITY_WIDTH(DENSITY_WIDTH), .PRESCALE_WIDTH(PRESCALE_WIDTH)
) mon_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .gpioLatch(gpioLatch), .pinOut(pinOut), .pinOe(pinOe),
    .masterClockSelect(masterClockSelect)
);

`default_nettype wire

// [testbench.sv]
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ADDRS [6] = '{8'h14, 8'h25, 8'h27, 8'h30, 8'h31, 8'h36};
    localparam logic [7:0] WMASK [6] = '{8'hFF, 8'hFF, 8'h10, 8'hFF, 8'hFF, 8'h27};
    localparam logic [7:0] RMASK [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F};

    logic       clk_sys;
    logic       reset_n;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdData;
    logic       gpioLatch;
    logic       pinOut;
    logic       pinOe;
    logic [7:0] masterClockSelect;
    int         errorCnt;
    int         checkCount;

    pdm_modulator dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .gpioLatch(gpioLatch), .pinOut(pinOut), .pinOe(pinOe),
        .masterClockSelect(masterClockSelect)
    );

    // 125 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Latch value wanders every cycle so the gpio path cannot pass by luck
    always @(posedge clk_sys) gpioLatch <= 1'($urandom);

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic finish_test();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkcnt(input int got, input int exp);
        checkCount++;
        if (got != exp) begin
            errorCnt++;
            $display("MISMATCH %0t high count got %0d exp %0d", $time, got, exp);
        end
    endtask : chkcnt

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        d = regRdData;
    endtask : rd

    // High cycles over 2**(m+s) cycles when only the top m word bits vary
    function automatic int exp_high(logic [15:0] w, int m, int s);
        int n;
        n = 0;
        for (int j = 0; j < m; j++) if (!w[15-j]) n += 1 << (m - j - 1);
        return n << s;
    endfunction : exp_high

    // Any window of this length holds every pattern phase exactly once
    task automatic duty(input logic [15:0] w, input int s, input int m);
        int         n;
        logic [7:0] d;
        wr(8'h36, 8'h20 | 8'(s));
        wr(8'h30, w[15:8]);
        wr(8'h31, w[7:0]);
        wr(8'h25, 8'h04);
        wr(8'h27, 8'h10);
        repeat ((2 << s) + 8) @(posedge clk_sys);
        n = 0;
        repeat (1 << (m + s)) begin
            @(negedge clk_sys);
            if (pinOut === 1'b1) n++;
        end
        chkcnt(n, exp_high(w, m, s));
        chk8({7'h0, pinOe}, 8'h01);
        rd(8'h36, d);
        chk8(d & 8'h7F, 8'h20 | 8'(s));
    endtask : duty

    task automatic gpio(input int n);
        logic g;
        repeat (3) @(negedge clk_sys);
        g = gpioLatch;
        repeat (n) begin
            @(negedge clk_sys);
            chk8({7'h0, pinOut}, {7'h0, g});
            g = gpioLatch;
        end
    endtask : gpio

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0]  d;
        logic [7:0]  v;
        logic [15:0] w;
        int          m;
        errorCnt = 0;
        checkCount = 0;
        reset_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        v = 8'($urandom(32'hD37C47A7));
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ADDRS[i], d);
            chk8(d, 8'h00);
        end
        rd(8'h24, d);
        chk8(d, pdm_pkg::READ_UNMAPPED);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            wr(ADDRS[i], v);
            rd(ADDRS[i], d);
            chk8(d & RMASK[i], v & WMASK[i]);
            if (i == 0) chk8(masterClockSelect, v);
        end
        wr(8'h36, 8'h00);
        wr(8'h27, 8'h10);
        gpio(20);
        wr(8'h36, 8'h20);
        wr(8'h27, 8'h00);
        gpio(20);
        duty(16'h7FFF, 0, 1);
        duty(16'hFFFF, 7, 1);
        duty(16'h3FFF, 7, 2);
        for (int s = 0; s < 8; s++) begin
            m = 1 + $urandom_range(2);
            w = 16'($urandom) | (16'hFFFF >> m);
            duty(w, s, m);
        end
        // Reset lands mid-cycle while the modulator is running
        @(negedge clk_sys);
        reset_n = 1'b0;
        #1;
        chk8({7'h0, pinOe}, 8'h00);
        chk8(masterClockSelect, 8'h00);
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(8'h30, d);
        chk8(d, 8'h00);
        finish_test();
    end

    // Watchdog far beyond the longest sequence
    initial begin
        #640000;
        errorCnt++;
        finish_test();
    end

endmodule : testbench

`default_nettype wire
